/* core/cc_array_pkg.sv */
// Package with constants for the five-module capture/compare array
package cc_array_pkg;
	localparam int NUM_MODULES = 5; // Capture/compare modules
	localparam int CNT_WIDTH = 16; // Shared counter width
	localparam int MODE_WIDTH = 8; // Mode register width
	// Mode register field positions
	localparam int MODE_IRQ_EN_BIT = 0;
	localparam int MODE_PWM_BIT = 1;
	localparam int MODE_TOG_BIT = 2;
	localparam int MODE_MAT_BIT = 3;
	localparam int MODE_FALL_BIT = 4;
	localparam int MODE_RISE_BIT = 5;
	localparam int MODE_CMP_EN_BIT = 6;
	localparam int MODE_WIDE_BIT = 7;
	// Reset values and counter maxima
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [7:0] LOW_MAX = 8'hFF;
	// Pin level must hold this many clocks to qualify
	localparam int FILTER_CYCLES = 2;
	// Operating modes
	typedef enum logic [2:0] {
		MODE_IDLE = 3'b000,
		MODE_CAPTURE = 3'b001,
		MODE_SW_TIMER = 3'b010,
		MODE_HS_OUT = 3'b011,
		MODE_FREQ_OUT = 3'b100,
		MODE_PWM8 = 3'b101,
		MODE_PWM16 = 3'b110
	} op_mode_t;
endpackage : cc_array_pkg

/* core/cc_module.sv */
// One capture/compare module: pin filter, mode decode, capture and compare
`timescale 1ns/1ps
module cc_module
	import cc_array_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [15:0] count, // Shared counter value
	input wire logic tick, // Counter advances this cycle
	input wire logic [7:0] mode_wdata, // Mode register write data
	input wire logic mode_we, // Mode register write strobe
	input wire logic [7:0] cpl_wdata, // Low compare byte write data
	input wire logic cpl_we, // Low compare byte write strobe
	input wire logic [7:0] cph_wdata, // High compare byte write data
	input wire logic cph_we, // High compare byte write strobe
	input wire logic flag_clr, // Software clears the event flag
	input wire logic pin_in, // Raw module pin level
	output logic [7:0] mode_rd, // Mode register readback
	output logic [7:0] cpl_rd, // Low compare byte readback
	output logic [7:0] cph_rd, // High compare byte readback
	output logic event_flag, // Sticky event flag
	output logic irq_req, // Module interrupt request
	output logic pin_level, // Filtered pin level
	output logic pin_out, // Driven pin level
	output logic pin_oe // Pin driven in high-speed, frequency and PWM modes
);
	logic sync1_q; // First synchroniser stage
	logic sync2_q; // Second synchroniser stage
	logic samp_q; // Delayed sample for hold check
	logic stable_q; // Filtered pin level
	logic [7:0] mode_q; // Mode register
	logic [7:0] cpl_q; // Low compare byte
	logic [7:0] cph_q; // High compare byte
	logic flag_q; // Event flag
	logic out_q; // Output pin state
	op_mode_t mode; // Decoded mode
	logic rise; // Qualified rising edge
	logic fall; // Qualified falling edge
	logic cap_evt; // Capture event
	logic match16; // Full-word match
	logic match8; // Low-byte match
	logic ovf16; // Counter wrap this tick
	logic ovf8; // Low byte wrap this tick
	logic set_evt; // Flag set event
	logic [7:0] half; // Frequency half period step
	logic [15:0] cmp_word; // Compare word
	logic [15:0] count_nxt; // Count value this tick moves to
	logic [7:0] cmp_low; // Low byte compare value

	// Synchroniser and two-cycle hold filter
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			samp_q <= 1'b0;
			stable_q <= 1'b0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
			samp_q <= sync2_q;
			if (sync2_q == samp_q) begin
				stable_q <= sync2_q;
			end
		end
	end

	// Mode decode from the mode register bits
	always_comb begin
		if (!mode_q[MODE_MAT_BIT] && !mode_q[MODE_TOG_BIT] && !mode_q[MODE_PWM_BIT]) begin
			// Either capture enable selects capture
			mode = (mode_q[MODE_RISE_BIT] || mode_q[MODE_FALL_BIT]) ? MODE_CAPTURE : MODE_IDLE;
		end else if (mode_q[MODE_RISE_BIT] || mode_q[MODE_FALL_BIT]) begin
			mode = MODE_IDLE;
		end else if (mode_q[MODE_TOG_BIT] && mode_q[MODE_PWM_BIT]) begin
			mode = MODE_FREQ_OUT;
		end else if (mode_q[MODE_PWM_BIT]) begin
			mode = mode_q[MODE_WIDE_BIT] ? MODE_PWM16 : MODE_PWM8;
		end else if (mode_q[MODE_MAT_BIT]) begin
			mode = mode_q[MODE_TOG_BIT] ? MODE_HS_OUT : MODE_SW_TIMER;
		end else begin
			mode = MODE_IDLE;
		end
	end

	assign rise = stable_q == 1'b0 && sync2_q && samp_q;
	assign fall = stable_q == 1'b1 && !sync2_q && !samp_q;
	assign cap_evt = mode == MODE_CAPTURE &&
		((rise && mode_q[MODE_RISE_BIT]) || (fall && mode_q[MODE_FALL_BIT]));
	assign cmp_word = {cph_q, cpl_q};
	// Matches look at the value the counter enters, so a zero compare meets the wrap
	assign count_nxt = count + 16'h0001;
	// In 8-bit PWM mode, at the low byte wrap the reload value is the one compared
	assign cmp_low = (mode == MODE_PWM8 && ovf8) ? cph_q : cpl_q;
	assign match16 = tick && count_nxt == cmp_word;
	assign match8 = tick && count_nxt[7:0] == cmp_low;
	assign ovf16 = tick && count == COUNT_MAX;
	assign ovf8 = tick && count[7:0] == LOW_MAX;
	assign half = cph_q; // Zero wraps to 256 in 8-bit add

	// Flag sets from capture or match with match flag enabled
	always_comb begin
		case (mode)
			MODE_CAPTURE: set_evt = cap_evt;
			MODE_SW_TIMER, MODE_HS_OUT: set_evt = mode_q[MODE_CMP_EN_BIT] && match16;
			MODE_FREQ_OUT: set_evt = mode_q[MODE_CMP_EN_BIT] && mode_q[MODE_MAT_BIT] && match8;
			MODE_PWM8: set_evt = mode_q[MODE_CMP_EN_BIT] && mode_q[MODE_MAT_BIT] && match8;
			MODE_PWM16: set_evt = mode_q[MODE_CMP_EN_BIT] && mode_q[MODE_MAT_BIT] && match16;
			default: set_evt = 1'b0;
		endcase
	end

	// Mode register with compare-enable side effects of byte writes
	always_ff @(posedge clk) begin
		if (srst) begin
			mode_q <= MODE_RESET;
		end else if (mode_we) begin
			mode_q <= mode_wdata;
		end else if (cph_we) begin
			mode_q[MODE_CMP_EN_BIT] <= 1'b1;
		end else if (cpl_we) begin
			mode_q[MODE_CMP_EN_BIT] <= 1'b0;
		end
	end

	// Compare bytes: writes, capture, frequency step, PWM reload
	always_ff @(posedge clk) begin
		if (srst) begin
			cpl_q <= BYTE_RESET;
			cph_q <= BYTE_RESET;
		end else begin
			if (cph_we) begin
				cph_q <= cph_wdata;
			end else if (cap_evt) begin
				cph_q <= count[15:8];
			end
			if (cpl_we) begin
				cpl_q <= cpl_wdata;
			end else if (cap_evt) begin
				cpl_q <= count[7:0];
			end else if (mode == MODE_FREQ_OUT && mode_q[MODE_CMP_EN_BIT] && match8) begin
				cpl_q <= cpl_q + half;
			end else if (mode == MODE_PWM8 && ovf8) begin
				cpl_q <= cph_q;
			end
		end
	end

	// Sticky flag, set wins over clear
	always_ff @(posedge clk) begin
		if (srst) begin
			flag_q <= 1'b0;
		end else if (set_evt) begin
			flag_q <= 1'b1;
		end else if (flag_clr) begin
			flag_q <= 1'b0;
		end
	end

	// Pin output per compare mode
	always_ff @(posedge clk) begin
		if (srst) begin
			out_q <= 1'b0;
		end else begin
			case (mode)
				MODE_HS_OUT: if (mode_q[MODE_CMP_EN_BIT] && match16) out_q <= ~out_q;
				MODE_FREQ_OUT: if (mode_q[MODE_CMP_EN_BIT] && match8) out_q <= ~out_q;
				MODE_PWM8: begin
					if (!mode_q[MODE_CMP_EN_BIT]) out_q <= 1'b0;
					else if (match8) out_q <= 1'b1;
					else if (ovf8) out_q <= 1'b0;
				end
				MODE_PWM16: begin
					if (!mode_q[MODE_CMP_EN_BIT]) out_q <= 1'b0;
					else if (match16) out_q <= 1'b1;
					else if (ovf16) out_q <= 1'b0;
				end
				default: out_q <= out_q;
			endcase
		end
	end

	assign mode_rd = mode_q;
	assign cpl_rd = cpl_q;
	assign cph_rd = cph_q;
	assign event_flag = flag_q;
	assign irq_req = flag_q && mode_q[MODE_IRQ_EN_BIT];
	assign pin_level = stable_q;
	assign pin_out = out_q;
	assign pin_oe = mode == MODE_HS_OUT || mode == MODE_FREQ_OUT || mode == MODE_PWM8 || mode == MODE_PWM16;
endmodule : cc_module

/* core/counter_array_capture_compare.sv */
// Top of the capture/compare array: shared counter and five modules
`timescale 1ns/1ps
module counter_array_capture_compare
	import cc_array_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic timebase_tick, // Selected timebase enable pulse
	input wire logic counter_run, // Counter run control
	input wire logic counter_we, // Load counter
	input wire logic [15:0] counter_wdata, // Counter load value
	input wire logic array_irq_enable, // Array interrupt enable
	input wire logic global_irq_enable, // Global interrupt enable
	input wire logic [4:0] module_mode_we, // Per-module mode write strobes
	input wire logic [7:0] module_mode_wdata, // Mode write data
	input wire logic [4:0] compare_low_we, // Per-module low byte strobes
	input wire logic [4:0] compare_high_we, // Per-module high byte strobes
	input wire logic [7:0] compare_wdata, // Compare byte write data
	input wire logic [4:0] event_flag_clr, // Per-module flag clears
	input wire logic [4:0] module_io_pin_in, // Raw pin levels
	output logic [15:0] counter_value, // Counter readback
	output logic [39:0] module_mode_reg, // Mode registers, module n at [8n+7:8n]
	output logic [39:0] compare_low_byte, // Low compare bytes
	output logic [39:0] compare_high_byte, // High compare bytes
	output logic [4:0] module_event_flag, // Sticky event flags
	output logic [4:0] module_io_pin_level, // Filtered pin levels
	output logic [4:0] module_io_pin_out, // Pin drive values
	output logic [4:0] module_io_pin_oe, // Pin drive enables
	output logic irq // Interrupt to CPU
);
	logic [15:0] count_q; // Shared counter
	logic tick; // Counter advances this cycle
	logic [4:0] mod_irq; // Per-module requests

	assign tick = timebase_tick && counter_run;

	// Shared counter, wraps naturally
	always_ff @(posedge clk) begin
		if (srst) begin
			count_q <= COUNT_RESET;
		end else if (counter_we) begin
			count_q <= counter_wdata;
		end else if (tick) begin
			count_q <= count_q + 16'h0001;
		end
	end

	// Module instances
	genvar gi;
	generate
		for (gi = 0; gi < NUM_MODULES; gi++) begin : g_mod
			cc_module u_mod (
				.clk(clk),
				.srst(srst),
				.count(count_q),
				.tick(tick),
				.mode_wdata(module_mode_wdata),
				.mode_we(module_mode_we[gi]),
				.cpl_wdata(compare_wdata),
				.cpl_we(compare_low_we[gi]),
				.cph_wdata(compare_wdata),
				.cph_we(compare_high_we[gi]),
				.flag_clr(event_flag_clr[gi]),
				.pin_in(module_io_pin_in[gi]),
				.mode_rd(module_mode_reg[8*gi +: 8]),
				.cpl_rd(compare_low_byte[8*gi +: 8]),
				.cph_rd(compare_high_byte[8*gi +: 8]),
				.event_flag(module_event_flag[gi]),
				.irq_req(mod_irq[gi]),
				.pin_level(module_io_pin_level[gi]),
				.pin_out(module_io_pin_out[gi]),
				.pin_oe(module_io_pin_oe[gi])
			);
		end
	endgenerate

	assign counter_value = count_q;
	assign irq = (|mod_irq) && array_irq_enable && global_irq_enable;

	// Checks
	AST_IRQ_GATE: assert property (@(posedge clk) disable iff (srst)
		irq == ((|(module_event_flag & {module_mode_reg[8*4+MODE_IRQ_EN_BIT],
			module_mode_reg[8*3+MODE_IRQ_EN_BIT], module_mode_reg[8*2+MODE_IRQ_EN_BIT],
			module_mode_reg[8*1+MODE_IRQ_EN_BIT], module_mode_reg[MODE_IRQ_EN_BIT]}))
			&& array_irq_enable && global_irq_enable))
		else $error("irq not gated by flags and all enables");
	AST_WRAP: assert property (@(posedge clk) disable iff (srst)
		(tick && !counter_we && count_q == COUNT_MAX) |=> count_q == COUNT_RESET)
		else $error("counter did not wrap");
	AST_HOLD: assert property (@(posedge clk) disable iff (srst)
		(!tick && !counter_we) |=> $stable(count_q))
		else $error("counter moved without tick");
	AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (srst)
		(module_event_flag[0] && !event_flag_clr[0]) |=> module_event_flag[0])
		else $error("flag dropped without clear");
	AST_CPL_CLEARS_EN: assert property (@(posedge clk) disable iff (srst)
		(compare_low_we[4] && !compare_high_we[4] && !module_mode_we[4]) |=>
		!module_mode_reg[8*4+MODE_CMP_EN_BIT])
		else $error("low write kept enable");
	AST_CPH_SETS_EN: assert property (@(posedge clk) disable iff (srst)
		(compare_high_we[4] && !module_mode_we[4]) |=> module_mode_reg[8*4+MODE_CMP_EN_BIT])
		else $error("high write left enable clear");
	AST_PWM_OFF_LOW: assert property (@(posedge clk) disable iff (srst)
		(module_mode_reg[39:32] == 8'h02 && $past(module_mode_reg[39:32]) == 8'h02) |-> !module_io_pin_out[4])
		else $error("pwm pin high while disabled");
	AST_FILTER: assert property (@(posedge clk) disable iff (srst)
		$rose(module_io_pin_level[0]) |-> $past(module_io_pin_in[0], 4) && $past(module_io_pin_in[0], 3))
		else $error("level qualified too early");
endmodule : counter_array_capture_compare

/* testbench/pin_env.sv */
// Far-side pin model: external sources on the five module pins
`timescale 1ns/1ps
module pin_env (
	input wire logic [4:0] pin_out, // Block drive values
	input wire logic [4:0] pin_oe, // Block drive enables
	input wire logic [4:0] ext_level, // External source levels
	output logic [4:0] pin_wire // Resolved pin levels
);
	// Block wins where it drives, external source elsewhere
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			pin_wire[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
		end
	end
endmodule : pin_env

/* testbench/counter_array_capture_compare_tb.sv */
// Self-checking bench for the capture/compare array
`timescale 1ns/1ps
module counter_array_capture_compare_tb;
	import cc_array_pkg::*;
	logic clk = 1'b0; // System clock
	logic srst = 1'b1; // Sync reset
	logic timebase_tick = 1'b0; // Counter advance pulse
	logic counter_run = 1'b1; // Counter always enabled
	logic counter_we = 1'b0; // Counter load strobe
	logic [15:0] counter_wdata = 16'h0000; // Counter load value
	logic array_irq_enable = 1'b0; // Array irq gate
	logic global_irq_enable = 1'b0; // Global irq gate
	logic [4:0] module_mode_we = 5'h00; // Mode strobes
	logic [7:0] module_mode_wdata = 8'h00; // Mode data
	logic [4:0] compare_low_we = 5'h00; // Low byte strobes
	logic [4:0] compare_high_we = 5'h00; // High byte strobes
	logic [7:0] compare_wdata = 8'h00; // Compare byte data
	logic [4:0] event_flag_clr = 5'h00; // Flag clears
	logic [4:0] ext = 5'h00; // External pin sources
	logic [4:0] pin_w; // Resolved pins
	logic [15:0] counter_value;
	logic [39:0] module_mode_reg, compare_low_byte, compare_high_byte;
	logic [4:0] module_event_flag, module_io_pin_level, module_io_pin_out, module_io_pin_oe;
	logic irq;
	int n_fail = 0; // Mismatches
	int compares = 0; // Comparisons made
	int tog, hi; // Toggle and high-sample counts of last run
	counter_array_capture_compare uut (.clk(clk), .srst(srst), .timebase_tick(timebase_tick),
		.counter_run(counter_run), .counter_we(counter_we), .counter_wdata(counter_wdata),
		.array_irq_enable(array_irq_enable), .global_irq_enable(global_irq_enable),
		.module_mode_we(module_mode_we), .module_mode_wdata(module_mode_wdata),
		.compare_low_we(compare_low_we), .compare_high_we(compare_high_we),
		.compare_wdata(compare_wdata), .event_flag_clr(event_flag_clr), .module_io_pin_in(pin_w),
		.counter_value(counter_value), .module_mode_reg(module_mode_reg),
		.compare_low_byte(compare_low_byte), .compare_high_byte(compare_high_byte),
		.module_event_flag(module_event_flag), .module_io_pin_level(module_io_pin_level),
		.module_io_pin_out(module_io_pin_out), .module_io_pin_oe(module_io_pin_oe), .irq(irq));
	pin_env u_env (.pin_out(module_io_pin_out), .pin_oe(module_io_pin_oe), .ext_level(ext), .pin_wire(pin_w));
	// Clock generator
	initial begin
		forever #5 clk = ~clk;
	end
	// Compare and count
	task chk(input logic [39:0] seen, input logic [39:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Verdict and end of run
	task wrap_up();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	task wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_n
	// Register write: k 0 mode, 1 low byte, 2 high byte
	task wr(input int k, input int m, input logic [7:0] d);
		module_mode_wdata = d;
		compare_wdata = d;
		module_mode_we = 5'(k == 0) << m;
		compare_low_we = 5'(k == 1) << m;
		compare_high_we = 5'(k == 2) << m;
		@(negedge clk);
		module_mode_we = 5'h00;
		compare_low_we = 5'h00;
		compare_high_we = 5'h00;
		@(negedge clk); // Idle cycle keeps back-to-back strobes apart
	endtask : wr
	task ld(input logic [15:0] v);
		counter_wdata = v;
		counter_we = 1'b1;
		@(negedge clk);
		counter_we = 1'b0;
	endtask : ld
	task clr(input logic [4:0] mask);
		event_flag_clr = mask;
		@(negedge clk);
		event_flag_clr = 5'h00;
	endtask : clr
	// Tick every cycle n times, counting pin toggles and high samples
	task run(input int n, input int m);
		logic p;
		tog = 0;
		hi = 0;
		p = module_io_pin_out[m];
		timebase_tick = 1'b1;
		for (int i = 0; i <= n; i++) begin
			@(negedge clk);
			if (module_io_pin_out[m] !== p) tog++;
			p = module_io_pin_out[m];
			if (i > 0 && p === 1'b1) hi++;
			if (i == n - 1) timebase_tick = 1'b0;
		end
	endtask : run
	// Edge capture with glitch rejection
	task t_cap(input logic [7:0] md, input int m);
		logic [15:0] v;
		v = {8'h5a, md};
		wr(0, m, md);
		ext[m] = 1'b0;
		wait_n(8);
		clr(5'h1f);
		ld(v);
		ext[m] = 1'b1;
		wait_n(1);
		ext[m] = 1'b0;
		wait_n(8);
		chk(module_event_flag[m], 1'b0);
		ext[m] = 1'b1;
		wait_n(8);
		chk(module_event_flag[m], md[5]);
		chk(module_io_pin_level[m], 1'b1);
		if (md[5]) chk({compare_high_byte[8*m +: 8], compare_low_byte[8*m +: 8]}, v);
		clr(5'h1f);
		ld(v + 16'h0001);
		ext[m] = 1'b0;
		wait_n(8);
		chk(module_event_flag[m], md[4]);
		if (md[4]) chk({compare_high_byte[8*m +: 8], compare_low_byte[8*m +: 8]}, v + 16'h0001);
	endtask : t_cap
	// Software timer, byte-write side effects, irq gating, sticky flag
	task t_tmr();
		wr(0, 1, 8'h49);
		wr(1, 1, 8'h10);
		chk(module_mode_reg[14], 1'b0);
		wr(2, 1, 8'h00);
		chk(module_mode_reg[14], 1'b1);
		clr(5'h1f);
		ld(16'h000e);
		chk(module_event_flag[1], 1'b0);
		run(4, 1);
		chk(module_event_flag[1], 1'b1);
		array_irq_enable = 1'b1;
		wait_n(1);
		chk(irq, 1'b0);
		global_irq_enable = 1'b1;
		wait_n(1);
		chk(irq, 1'b1);
		array_irq_enable = 1'b0;
		wait_n(20);
		chk(irq, 1'b0);
		chk(module_event_flag[1], 1'b1);
		clr(5'h02);
		chk(module_event_flag[1], 1'b0);
	endtask : t_tmr
	// Output modes: high-speed, frequency, both PWM widths
	task t_out();
		logic [7:0] h[3] = '{8'hc0, 8'h00, 8'hff};
		wr(0, 2, 8'h4c);
		wr(1, 2, 8'h05);
		wr(2, 2, 8'h00);
		ld(16'h0000);
		run(300, 2);
		chk(tog, 1);
		chk(module_io_pin_oe[2], 1'b1);
		wr(0, 3, 8'h46);
		wr(1, 3, 8'h00);
		wr(2, 3, 8'h04);
		ld(16'hffff);
		run(64, 3);
		chk(tog, 16);
		wr(1, 3, 8'h00);
		wr(2, 3, 8'h00);
		ld(16'h0001);
		run(512, 3);
		chk(tog, 2);
		wr(0, 4, 8'h42);
		wr(1, 4, 8'hc0);
		foreach (h[i]) begin
			wr(2, 4, h[i]);
			ld(16'h0000);
			run(256, 4);
			run(512, 4);
			chk(hi, (256 - int'(h[i])) * 2);
		end
		wr(1, 4, 8'hc0);
		run(512, 4);
		chk(hi, 0);
		wr(0, 4, 8'hcb);
		wr(1, 4, 8'hf0);
		wr(2, 4, 8'hff);
		ld(16'hff00);
		run(512, 4);
		chk(hi, 16);
		chk(module_event_flag[4], 1'b1);
		chk(counter_value, 16'h0100);
	endtask : t_out
	// Main sequence
	initial begin
		wait_n(10);
		srst = 1'b0;
		wait_n(1);
		chk(module_mode_reg, 40'h0);
		chk(module_io_pin_oe, 5'h00);
		t_cap(8'h20, 0);
		t_cap(8'h10, 0);
		t_cap(8'h30, 0);
		t_tmr();
		t_out();
		wrap_up();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		wrap_up();
	end
endmodule : counter_array_capture_compare_tb
